// *** logic/pbf_formatter.sv ***
// Purpose: pcm packet body formatter with avalon-mm control registers
// Assumes: upstream items are frame-aligned; sync items open a minor frame
// Notes: config is latched per packet so register writes never split a packet
`default_nettype none
module pbf_formatter
  import pbf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic in_valid,
  output logic in_ready,
  input wire pbf_item_s in_item,
  input wire logic [63:0] ts_in,
  input wire logic [3:0] lock_in,
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_data,
  output logic out_wide,
  output logic pkt_done
);
  pbf_state_e state_r;
  pbf_cfg_s cfg_r;
  logic [31:0] ctrl_r;
  logic [15:0] frames_r;
  logic [31:0] csdw_r;
  logic [31:0] pkts_r;
  logic [31:0] drops_r;
  logic ack_r;
  logic [63:0] ts_r;
  logic [3:0] lock_r;
  logic [19:0] fb_r;
  logic [15:0] cnt_r;
  logic [6:0] syn_rem_r;
  logic [6:0] syn_idx_r;
  logic push_valid;
  logic push_ready;
  pbf_push_s push;
  logic fire;
  logic drop;
  logic unp;
  logic thru;
  logic [6:0] sy_k;
  logic [6:0] sy_base;
  logic [6:0] sy_extra;
  logic [6:0] sy_plen;
  logic [6:0] sy_cont;
  logic sy_last;
  logic [63:0] sy_shift;
  logic [6:0] d_len;
  logic [6:0] fill;
  logic [4:0] fb_mod;
  logic frames_hit;
  logic fill_go;
  logic [15:0] unit_data;
  logic unit_valid;
  logic unit_ready;
  pbf_mode_e new_mode;
  logic [2:0] new_hot;
  logic [2:0] cfg_hot;

  function automatic logic [2:0] mode_hot(input pbf_mode_e m);
    // unused encoding falls back to unpacked so one bit is always set
    case (m)
      PBF_MODE_THRU: mode_hot = 3'b100;
      PBF_MODE_PACKED: mode_hot = 3'b010;
      default: mode_hot = 3'b001;
    endcase
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // 16-bit alignment sends the low half first, 32-bit sends the word whole
  function automatic logic [31:0] order32(input logic [31:0] w, input logic a32);
    return a32 ? w : {w[15:0], w[31:16]};
  endfunction

  assign cfg_hot = mode_hot(cfg_r.mode);
  assign unp = cfg_hot[0];
  assign thru = cfg_hot[2];
  assign new_mode = pbf_mode_e'(ctrl_r[PBF_CTRL_MODE +: 2]);
  assign new_hot = mode_hot(new_mode);
  assign fire = push_valid & push_ready;

  // ---------------- register bus: one wait state per access ----------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~ack_r) begin
      case (avs_address)
        PBF_REG_CTRL: avs_readdata <= ctrl_r;
        PBF_REG_FRAMES: avs_readdata <= {16'h0, frames_r};
        PBF_REG_STATUS: avs_readdata <= {27'h0, state_r, state_r != PBF_ST_IDLE};
        PBF_REG_CSDW: avs_readdata <= csdw_r;
        PBF_REG_PKTS: avs_readdata <= pkts_r;
        PBF_REG_DROPS: avs_readdata <= drops_r;
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= PBF_CTRL_RST;
      frames_r <= PBF_FRAMES_RST;
    end else if (avs_write & ack_r) begin
      if (avs_address == PBF_REG_CTRL) begin
        ctrl_r <= be_merge(ctrl_r, avs_writedata, avs_byteenable) & 32'h0000_000F;
      end
      if (avs_address == PBF_REG_FRAMES) begin
        frames_r <= 16'(be_merge({16'h0, frames_r}, avs_writedata, avs_byteenable));
      end
    end
  end

  // ---------------- sync splitting arithmetic ----------------
  always_comb begin
    if (in_item.len <= PBF_UNIT_BITS) begin
      sy_k = 7'h1;
    end else if (in_item.len <= PBF_WORD_BITS) begin
      sy_k = 7'h2;
    end else if (cfg_r.align32) begin
      sy_k = (in_item.len + PBF_WORD_BITS - 7'h1) / PBF_WORD_BITS;
    end else begin
      sy_k = (in_item.len + PBF_UNIT_BITS - 7'h1) / PBF_UNIT_BITS;
    end
    sy_base = in_item.len / sy_k;
    sy_extra = in_item.len % sy_k;
    if (unp) begin
      // the later pieces carry the spare bits, one each
      sy_plen = sy_base + ((syn_idx_r >= sy_k - sy_extra) ? 7'h1 : 7'h0);
      sy_cont = (cfg_r.align32 && in_item.len > PBF_WORD_BITS) ? PBF_WORD_BITS
                                                              : PBF_UNIT_BITS;
    end else begin
      sy_plen = (syn_rem_r > PBF_WORD_BITS) ? PBF_WORD_BITS : syn_rem_r;
      sy_cont = sy_plen;
    end
    sy_last = (syn_rem_r <= sy_plen);
    sy_shift = in_item.data >> (syn_rem_r - sy_plen);
  end

  // ---------------- data sizing and frame fill ----------------
  always_comb begin
    d_len = (in_item.len > PBF_WORD_BITS) ? PBF_WORD_BITS : in_item.len;
    fb_mod = cfg_r.align32 ? fb_r[4:0] : {1'b0, fb_r[3:0]};
    if (fb_mod == 5'h0) begin
      fill = 7'h0;
    end else begin
      // Y = N - (L mod N) zero bits; also yields the odd 16-bit zero word
      fill = (cfg_r.align32 ? PBF_WORD_BITS : PBF_UNIT_BITS) - {2'b00, fb_mod};
    end
  end

  assign frames_hit = ((cnt_r + 16'h1) >= cfg_r.frames);
  assign fill_go = (state_r == PBF_ST_FILL) & ((fill == 7'h0) | push_ready);

  // ---------------- push generation ----------------
  always_comb begin
    push_valid = 1'b0;
    push.data = 32'h0;
    push.len = 6'h0;
    case (state_r)
      PBF_ST_CSDW: begin
        push_valid = 1'b1;
        push.data = order32(csdw_r, cfg_r.align32);
        push.len = 6'(PBF_WORD_BITS);
      end
      PBF_ST_TS_LO: begin
        push_valid = 1'b1;
        push.data = order32(ts_r[31:0], cfg_r.align32);
        push.len = 6'(PBF_WORD_BITS);
      end
      PBF_ST_TS_HI: begin
        push_valid = 1'b1;
        push.data = order32(ts_r[63:32], cfg_r.align32);
        push.len = 6'(PBF_WORD_BITS);
      end
      PBF_ST_HDR: begin
        push_valid = 1'b1;
        // under 32-bit alignment the upper 16 bits go out as zeros
        push.data = {16'h0, lock_r, 12'h0};
        push.len = cfg_r.align32 ? 6'(PBF_WORD_BITS) : 6'(PBF_UNIT_BITS);
      end
      PBF_ST_SYNC: begin
        push_valid = in_valid;
        // pad occupies the upper bits of the container
        push.data = pbf_mask32(sy_shift[31:0], sy_plen);
        push.len = 6'(sy_cont);
      end
      PBF_ST_DATA: begin
        push_valid = in_valid & ~in_item.sync;
        push.data = pbf_mask32(in_item.data[31:0], d_len);
        if (unp) begin
          push.len = (d_len > PBF_UNIT_BITS) ? 6'(PBF_WORD_BITS) : 6'(PBF_UNIT_BITS);
        end else begin
          push.len = 6'(d_len);
        end
      end
      PBF_ST_THRU: begin
        push_valid = in_valid;
        push.data = pbf_mask32(in_item.data[31:0], d_len);
        push.len = 6'(d_len);
      end
      PBF_ST_FILL: begin
        push_valid = (fill != 7'h0);
        push.len = 6'(fill);
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end

  // items ahead of a frame start are dropped so only whole frames go out
  assign drop = in_valid & ~in_item.sync &
                (((state_r == PBF_ST_IDLE) & ctrl_r[PBF_CTRL_EN] & ~new_hot[2]) |
                 (state_r == PBF_ST_HUNT));

  always_comb begin
    case (state_r)
      PBF_ST_SYNC: in_ready = push_ready & sy_last;
      PBF_ST_DATA: in_ready = push_ready & ~in_item.sync;
      PBF_ST_THRU: in_ready = push_ready;
      default: in_ready = drop;
    endcase
  end

  // ---------------- sequencing ----------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= PBF_ST_IDLE;
    end else begin
      case (state_r)
        PBF_ST_IDLE: begin
          if (ctrl_r[PBF_CTRL_EN] & in_valid & (new_hot[2] | in_item.sync)) begin
            state_r <= PBF_ST_CSDW;
          end
        end
        PBF_ST_CSDW: begin
          if (fire) begin
            state_r <= thru ? PBF_ST_THRU : PBF_ST_HUNT;
          end
        end
        PBF_ST_HUNT: begin
          if (in_valid & in_item.sync) begin
            state_r <= PBF_ST_TS_LO;
          end
        end
        PBF_ST_TS_LO: begin
          if (fire) begin
            state_r <= PBF_ST_TS_HI;
          end
        end
        PBF_ST_TS_HI: begin
          if (fire) begin
            state_r <= PBF_ST_HDR;
          end
        end
        PBF_ST_HDR: begin
          if (fire) begin
            state_r <= PBF_ST_SYNC;
          end
        end
        PBF_ST_SYNC: begin
          if (fire & sy_last) begin
            state_r <= PBF_ST_DATA;
          end
        end
        PBF_ST_DATA: begin
          // a sync arriving early closes the frame without consuming it
          if (in_valid & (in_item.sync | (push_ready & in_item.last))) begin
            state_r <= PBF_ST_FILL;
          end
        end
        PBF_ST_THRU: begin
          if (fire & frames_hit) begin
            state_r <= PBF_ST_FILL;
          end
        end
        PBF_ST_FILL: begin
          if (fill_go) begin
            state_r <= (thru | frames_hit) ? PBF_ST_IDLE : PBF_ST_HUNT;
          end
        end
        default: state_r <= PBF_ST_IDLE;
      endcase
    end
  end

  // per-packet config and channel word, taken at packet start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= '{mode: PBF_MODE_UNPACKED, align32: 1'b0, frames: PBF_FRAMES_RST};
      csdw_r <= 32'h0;
    end else if ((state_r == PBF_ST_IDLE) & ctrl_r[PBF_CTRL_EN] & in_valid &
                 (new_hot[2] | in_item.sync)) begin
      cfg_r.mode <= new_mode;
      cfg_r.align32 <= ctrl_r[PBF_CTRL_ALIGN];
      cfg_r.frames <= frames_r;
      csdw_r <= 32'h0; // bits 31, 29-22 stay zero
      csdw_r[PBF_CS_IPH] <= ~new_hot[2];
      csdw_r[PBF_CS_ALIGN] <= ctrl_r[PBF_CTRL_ALIGN];
      csdw_r[PBF_CS_THRU] <= new_hot[2];
      csdw_r[PBF_CS_PACKED] <= new_hot[1];
      csdw_r[PBF_CS_UNPACKED] <= new_hot[0];
      // offset means something only in unpacked mode
      csdw_r[PBF_OFFS_W-1:0] <= new_hot[0] ? in_item.word_idx : 18'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ts_r <= 64'h0;
      lock_r <= 4'h0;
    end else if ((state_r == PBF_ST_HUNT) & in_valid & in_item.sync) begin
      ts_r <= ts_in;
      lock_r <= lock_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syn_rem_r <= 7'h0;
      syn_idx_r <= 7'h0;
    end else if ((state_r == PBF_ST_HDR) & fire) begin
      syn_rem_r <= in_item.len;
      syn_idx_r <= 7'h0;
    end else if ((state_r == PBF_ST_SYNC) & fire) begin
      syn_rem_r <= syn_rem_r - sy_plen;
      syn_idx_r <= syn_idx_r + 7'h1;
    end
  end

  // running bit count keeps the frame boundary arithmetic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fb_r <= 20'h0;
    end else if (state_r == PBF_ST_IDLE) begin
      fb_r <= 20'h0;
    end else if (fire) begin
      fb_r <= fb_r + 20'(push.len);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 16'h0;
    end else if (state_r == PBF_ST_IDLE) begin
      cnt_r <= 16'h0;
    end else if ((state_r == PBF_ST_THRU & fire) | (fill_go & ~thru)) begin
      cnt_r <= cnt_r + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pkt_done <= 1'b0;
      pkts_r <= 32'h0;
    end else begin
      pkt_done <= fill_go & (thru | frames_hit);
      if (fill_go & (thru | frames_hit)) begin
        pkts_r <= pkts_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drops_r <= 32'h0;
    end else if (drop) begin
      drops_r <= drops_r + 32'h1;
    end
  end

  // ---------------- output path ----------------
  pbf_bit_packer u_packer (
    .clk(clk),
    .sys_rst(sys_rst),
    .push_valid(push_valid),
    .push_ready(push_ready),
    .push(push),
    .unit_valid(unit_valid),
    .unit_ready(unit_ready),
    .unit_data(unit_data)
  );

  pbf_word_pair u_pair (
    .clk(clk),
    .sys_rst(sys_rst),
    .wide(cfg_r.align32),
    .in_valid(unit_valid),
    .in_ready(unit_ready),
    .in_data(unit_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data),
    .out_wide(out_wide)
  );
endmodule
`default_nettype wire

// *** pkg/pbf_pkg.sv ***
// Purpose: shared constants, types and helpers of the pcm packet body formatter
// Assumes: single clock, synchronous active-high reset
// Notes: Function
// Function
// - bit 21 shows alignment, bits 23-22 zero
// - bit 20 high only in throughput mode
// - bit 19 high only in packed mode
// - bit 18 high only in unpacked mode
// - bits 17-0 carry word offset, unpacked only
// - framed modes carry whole minor frames only
// - throughput: raw bits, no intra headers
// - minor frames start/end on alignment boundary
// - data word bits never altered
// - unpacked: pad each word to 16 bits
// - unpacked 32-bit: zero word on odd count
// - sync over 16 bits splits in two
// - odd split gives second word extra bit
// - long sync uses ceil(bits/16 or 32) words
// - uneven split: first word smaller, later +1
// - packed: no per-word padding
// - packed: fill N - (L mod N) bits
// - intra header precedes each sync pattern
// - data header 2 bytes, or 4 zero-topped
// - bit 30 clear in throughput, else set
// - 32-bit words filled right to left
`default_nettype none
package pbf_pkg;
  localparam logic [3:0] PBF_REG_CTRL = 4'h0;
  localparam logic [3:0] PBF_REG_FRAMES = 4'h1;
  localparam logic [3:0] PBF_REG_STATUS = 4'h2;
  localparam logic [3:0] PBF_REG_CSDW = 4'h3;
  localparam logic [3:0] PBF_REG_PKTS = 4'h4;
  localparam logic [3:0] PBF_REG_DROPS = 4'h5;
  localparam int PBF_CTRL_EN = 0;
  localparam int PBF_CTRL_MODE = 1;
  localparam int PBF_CTRL_ALIGN = 3;
  localparam logic [31:0] PBF_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PBF_FRAMES_RST = 16'h0001;
  localparam int PBF_CS_IPH = 30;
  localparam int PBF_CS_ALIGN = 21;
  localparam int PBF_CS_THRU = 20;
  localparam int PBF_CS_PACKED = 19;
  localparam int PBF_CS_UNPACKED = 18;
  localparam int PBF_OFFS_W = 18;
  localparam logic [6:0] PBF_UNIT_BITS = 7'h10;
  localparam logic [6:0] PBF_WORD_BITS = 7'h20;
  localparam int PBF_LOCK_LSB = 12;

  typedef enum logic [1:0] {
    PBF_MODE_UNPACKED = 2'b00,
    PBF_MODE_PACKED = 2'b01,
    PBF_MODE_THRU = 2'b10
  } pbf_mode_e;

  typedef enum logic [3:0] {
    PBF_ST_IDLE = 4'b0000,
    PBF_ST_CSDW = 4'b0001,
    PBF_ST_HUNT = 4'b0010,
    PBF_ST_TS_LO = 4'b0011,
    PBF_ST_TS_HI = 4'b0100,
    PBF_ST_HDR = 4'b0101,
    PBF_ST_SYNC = 4'b0110,
    PBF_ST_DATA = 4'b0111,
    PBF_ST_THRU = 4'b1000,
    PBF_ST_FILL = 4'b1001
  } pbf_state_e;

  // one upstream item: a sync pattern or a data word, right-justified
  typedef struct packed {
    logic [63:0] data;
    logic [6:0] len;
    logic sync;
    logic last;
    logic [17:0] word_idx;
  } pbf_item_s;

  typedef struct packed {
    logic [31:0] data;
    logic [5:0] len;
  } pbf_push_s;

  typedef struct packed {
    pbf_mode_e mode;
    logic align32;
    logic [15:0] frames;
  } pbf_cfg_s;

  function automatic logic [31:0] pbf_mask32(input logic [31:0] d, input logic [6:0] n);
    logic [31:0] m;
    m = (n >= PBF_WORD_BITS) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
    return d & m;
  endfunction
endpackage
`default_nettype wire

// *** logic/pbf_bit_packer.sv ***
// Purpose: pack variable-length bit fields msb first into 16-bit units
// Assumes: push length 0..32, caller keeps the data masked to its length
// Notes: accepts a push only while 16 or fewer bits wait, so 48 bits suffice
`default_nettype none
module pbf_bit_packer
  import pbf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic push_valid,
  output logic push_ready,
  input wire pbf_push_s push,
  output logic unit_valid,
  input wire logic unit_ready,
  output logic [15:0] unit_data
);
  logic [47:0] acc_r;
  logic [5:0] cnt_r;
  logic do_push;
  logic do_emit;

  assign push_ready = (cnt_r <= 6'(PBF_UNIT_BITS));
  assign unit_valid = (cnt_r >= 6'(PBF_UNIT_BITS));
  assign unit_data = 16'(acc_r >> (cnt_r - 6'(PBF_UNIT_BITS)));
  assign do_push = push_valid & push_ready;
  assign do_emit = unit_valid & unit_ready;

  // bits are never reordered or altered, only concatenated
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_r <= 48'h0;
    end else if (do_push) begin
      acc_r <= (acc_r << push.len) | {16'h0, push.data};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 6'h0;
    end else begin
      cnt_r <= cnt_r + (do_push ? push.len : 6'h0) - (do_emit ? 6'(PBF_UNIT_BITS) : 6'h0);
    end
  end
endmodule
`default_nettype wire

// *** logic/pbf_word_pair.sv ***
// Purpose: join 16-bit units into 32-bit output words under 32-bit alignment
// Assumes: alignment only changes while the path is empty
// Notes: first unit lands in bits 31-16, the second in bits 15-0
`default_nettype none
module pbf_word_pair (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wide,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_data,
  output logic out_wide
);
  logic [15:0] hold_r;
  logic half_r;
  logic take;
  logic load;

  // the first half never needs the output register, so it is always taken
  assign in_ready = ~out_valid | out_ready | (wide & ~half_r);
  assign take = in_valid & in_ready;
  assign load = take & (~wide | half_r);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      half_r <= 1'b0;
      hold_r <= 16'h0;
    end else if (take & wide) begin
      half_r <= ~half_r;
      hold_r <= in_data;
    end
  end

  // serial stream shifts in from the right, earliest bits end up leftmost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_data <= 32'h0;
      out_wide <= 1'b0;
    end else if (load) begin
      out_data <= wide ? {hold_r, in_data} : {16'h0, in_data};
      out_wide <= wide;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
    end else if (load) begin
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** sim/pbf_formatter_checker.sv ***
// Purpose: port-level checks of the packet body formatter
// Assumes: one clock, synchronous active-high reset
// Notes: mode is not visible at the ports, so mode-dependent layout is checked by the bench
`default_nettype none
module pbf_formatter_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [31:0] out_data,
  input wire logic out_wide,
  input wire logic pkt_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_held;
    out_valid && $stable(out_data) && $stable(out_wide);
  endsequence
  chk_bus_one_wait: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
    else $error("bus access wait state count wrong");
  chk_bus_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h5
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_readdata_kept: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_out_held: assert property (out_valid && !out_ready |=> s_held)
    else $error("stalled output word changed");
  chk_done_pulse: assert property (pkt_done |=> !pkt_done)
    else $error("packet done longer than one cycle");
  chk_narrow_top: assert property (out_valid && !out_wide |-> out_data[31:16] == 16'h0)
    else $error("narrow word has upper bits set");
  chk_reset_quiet: assert property ($fell(sys_rst) |-> !out_valid && !pkt_done && !in_ready)
    else $error("outputs active right after reset");
endmodule
bind pbf_formatter pbf_formatter_checker pbf_formatter_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_wide(out_wide), .pkt_done(pkt_done)
);
`default_nettype wire

// *** sim/pbf_frame_partner.sv ***
// Purpose: frame synchronizer source and packet writer sink model
// Assumes: items offered just after an edge and held until taken
// Notes: the sink can stall every other cycle to push back into the formatter
`default_nettype none
module pbf_frame_partner
  import pbf_pkg::*;
(
  input wire logic clk,
  output logic in_valid,
  input wire logic in_ready,
  output pbf_item_s in_item,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [31:0] out_data,
  input wire logic out_wide
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall = 1'b0;
  int n_late = 0;
  logic [32:0] got[$];
  initial begin
    in_valid = 1'b0;
    in_item = '0;
    out_ready = 1'b1;
  end
  always @(posedge clk) begin
    out_ready <= stall ? ~out_ready : 1'b1;
    if (out_valid && out_ready) got.push_back({out_wide, out_data});
  end
  // a released item bus shows inverted data, not the last value
  task automatic send(input logic [63:0] d, input logic [6:0] n, input logic s,
                      input logic l, input logic [17:0] w);
    int k;
    @(posedge clk);
    in_valid <= 1'b1;
    in_item <= '{d, n, s, l, w};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!in_ready && k < 300);
    if (!in_ready) n_late++;
    in_valid <= 1'b0;
    in_item.data <= ~d;
  endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the packet body formatter
// Assumes: one minor frame per packet, frames register at its reset value
// Notes: expected words come from the mode rules, never from the design
`default_nettype none
module testbench;
  import pbf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] SYNC = 64'hFAF320;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, out_data, rd;
  logic avs_waitrequest, in_valid, in_ready, out_valid, out_ready, out_wide, pkt_done;
  pbf_item_s in_item;
  logic [32:0] exp[$];
  int n_fail = 0;
  int n_compared = 0;
  int n_done = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (pkt_done) n_done++;
  pbf_formatter pbf_formatter_inst (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_ready(in_ready), .in_item(in_item), .ts_in(64'h0123_4567_89AB_CDEF),
    .lock_in(4'hF), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_wide(out_wide), .pkt_done(pkt_done)
  );
  pbf_frame_partner pbf_frame_partner_inst (
    .clk(clk), .in_valid(in_valid), .in_ready(in_ready), .in_item(in_item),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_wide(out_wide)
  );
  task automatic close_out;
    n_fail += pbf_frame_partner_inst.n_late;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest && k < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic e16(input logic [15:0] w[$]);
    foreach (w[i]) exp.push_back({17'h0, w[i]});
  endtask
  task automatic e32(input logic [31:0] w[$]);
    foreach (w[i]) exp.push_back({1'b1, w[i]});
  endtask
  // sync, then up to three data words of 12, 16 and 8 bits
  task automatic frame(input logic [17:0] w, input int nd);
    pbf_frame_partner_inst.send(SYNC, 7'd24, 1'b1, 1'b0, w);
    pbf_frame_partner_inst.send(64'hABC, 7'd12, 1'b0, nd == 1, w + 18'h1);
    if (nd > 1) pbf_frame_partner_inst.send(64'h1234, 7'd16, 1'b0, nd == 2, w + 18'h2);
    if (nd > 2) pbf_frame_partner_inst.send(64'h5A, 7'd8, 1'b0, 1'b1, w + 18'h3);
  endtask
  task automatic start(input logic [31:0] ctrl);
    exp.delete();
    pbf_frame_partner_inst.got.delete();
    bus(1'b1, PBF_REG_CTRL, ctrl);
  endtask
  task automatic finish_pkt(input logic [31:0] cs);
    int k;
    k = 0;
    while (pbf_frame_partner_inst.got.size() < exp.size() && k < 600) begin
      @(posedge clk);
      k++;
    end
    foreach (exp[i]) check(pbf_frame_partner_inst.got[i], exp[i]);
    bus(1'b0, PBF_REG_CSDW, 32'h0);
    check({1'b0, rd}, {1'b0, cs});
    $display("test done, %0d words", exp.size());
    if (k >= 600) begin
      n_fail++;
      close_out();
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, 4'hF, 32'h0);
    // data without a sync is dropped so no partial frame is written
    start(32'h1);
    pbf_frame_partner_inst.send(64'hABC, 7'd12, 1'b0, 1'b1, 18'h1);
    bus(1'b0, PBF_REG_DROPS, 32'h0);
    check({1'b0, rd}, 33'h1);
    $display("test done, drops");
    // unpacked, 16-bit alignment, slow sink
    start(32'h1);
    pbf_frame_partner_inst.stall <= 1'b1;
    frame(18'h2A5, 3);
    e16('{16'h02A5, 16'h4004, 16'hCDEF, 16'h89AB, 16'h4567, 16'h0123, 16'hF000,
          16'h0FAF, 16'h0320, 16'h0ABC, 16'h1234, 16'h005A});
    finish_pkt(32'h4004_02A5);
    pbf_frame_partner_inst.stall <= 1'b0;
    // packed, 16-bit alignment: 52 frame bits, 12 fill bits
    start(32'h3);
    frame(18'h0, 2);
    e16('{16'h0000, 16'h4008, 16'hCDEF, 16'h89AB, 16'h4567, 16'h0123, 16'hF000,
          16'hFAF3, 16'h20AB, 16'hC123, 16'h4000});
    finish_pkt(32'h4008_0000);
    // unpacked, 32-bit alignment: odd unit count gets a zero unit
    start(32'h9);
    frame(18'h2A5, 1);
    e32('{32'h4024_02A5, 32'h89AB_CDEF, 32'h0123_4567, 32'h0000_F000, 32'h0FAF_0320,
          32'h0ABC_0000});
    finish_pkt(32'h4024_02A5);
    // throughput, 16-bit alignment: raw bits, no headers
    start(32'h5);
    pbf_frame_partner_inst.send(64'hA5C3_1E0F, 7'd32, 1'b0, 1'b0, 18'h0);
    e16('{16'h0000, 16'h0010, 16'hA5C3, 16'h1E0F});
    finish_pkt(32'h0010_0000);
    // unpacked, 16-bit alignment, 35-bit sync split 11+12+12
    start(32'h1);
    pbf_frame_partner_inst.send(64'h1_2345_6789, 7'd35, 1'b1, 1'b0, 18'h0);
    pbf_frame_partner_inst.send(64'hABC, 7'd12, 1'b0, 1'b1, 18'h1);
    e16('{16'h0000, 16'h4004, 16'hCDEF, 16'h89AB, 16'h4567, 16'h0123, 16'hF000,
          16'h0123, 16'h0456, 16'h0789, 16'h0ABC});
    finish_pkt(32'h4004_0000);
    bus(1'b0, PBF_REG_PKTS, 32'h0);
    check({1'b0, rd}, 33'h5);
    check(33'(n_done), 33'h5);
    close_out();
  end
endmodule
`default_nettype wire
